// ===== logic/hmpc_pkg.sv
`default_nettype none
package hmpc_pkg;

  // Halt instruction opcode
  localparam logic [7:0]  HALT_OPCODE        = 8'h8E;

  // Stabilisation / wake delay, in CPU cycles (one CPU cycle per pclk cycle)
  localparam int          CLK_PERIOD_NS      = 20;
  localparam int          PCLK_PER_TCPU      = 1;
  localparam int          STAB_SHORT_TCPU    = 256;
  localparam int          STAB_LONG_TCPU     = 4096;
  localparam int          DLY_W              = 13;
  localparam logic [DLY_W-1:0] STAB_SHORT_CYC = DLY_W'(STAB_SHORT_TCPU * PCLK_PER_TCPU);
  localparam logic [DLY_W-1:0] STAB_LONG_CYC  = DLY_W'(STAB_LONG_TCPU * PCLK_PER_TCPU);

  // Interrupt mask level forced on halt entry
  localparam logic [1:0]  IMASK_HALT_LEVEL   = 2'b10;

  // APB register byte addresses
  localparam logic [7:0]  ADDR_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_STATE         = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT      = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK      = 8'h0C;

  // Field positions
  localparam int          CTRL_TB_EN_BIT     = 0;
  localparam int          ST_STATE_LSB       = 0;
  localparam int          ST_WIN_BIT         = 4;
  localparam int          ST_LONG_BIT        = 5;
  localparam int          ST_WDGOPT_BIT      = 6;
  localparam int          EV_HALT_BIT        = 0;
  localparam int          EV_IRQ_WAKE_BIT    = 1;
  localparam int          EV_RST_WAKE_BIT    = 2;
  localparam int          EV_EARLY_BIT       = 3;
  localparam int          EV_W               = 4;

  // Reset values and strap settle count
  localparam logic        CTRL_RESET         = 1'b0;
  localparam logic [EV_W-1:0] IRQ_STAT_RESET = 4'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [1:0]  CFG_SETTLE_CYC     = 2'h3;

  typedef enum logic [2:0] {
    HMPC_RUN,
    HMPC_FULL_HALT,
    HMPC_ACTIVE_HALT,
    HMPC_STABILISE,
    HMPC_GUARD_HALT
  } hmpc_state_e;

  function automatic logic [DLY_W-1:0] hmpc_dly_len(input logic long_sel);
    return long_sel ? STAB_LONG_CYC : STAB_SHORT_CYC;
  endfunction

  function automatic logic hmpc_osc_stopped(input hmpc_state_e s);
    return (s == HMPC_FULL_HALT) || (s == HMPC_GUARD_HALT);
  endfunction

endpackage
`default_nettype wire

// ===== logic/hmpc_dly_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hmpc_dly_if;
  import hmpc_pkg::*;
  logic             start;
  logic             long_sel;
  logic             busy;
  logic             done;
  logic [DLY_W-1:0] remain;

  modport ctl (output start, output long_sel, input busy, input done, input remain);
  modport tmr (input start, input long_sel, output busy, output done, output remain);
endinterface
`default_nettype wire

// ===== logic/hmpc_delay.sv
`timescale 1ns/1ps
`default_nettype none
module hmpc_delay
  import hmpc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  hmpc_dly_if.tmr   dly
);

  logic [DLY_W-1:0] cnt_reg;
  logic             busy_reg;

  // A start while busy restarts the count from full length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (dly.start) begin
      cnt_reg  <= hmpc_dly_len(dly.long_sel) - DLY_W'(1);
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - DLY_W'(1);
      end
    end
  end

  assign dly.busy   = busy_reg;
  assign dly.done   = busy_reg && (cnt_reg == '0) && !dly.start;
  assign dly.remain = cnt_reg;

endmodule // hmpc_delay
`default_nettype wire

// ===== logic/hmpc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE1) Halt opcode enters full halt if timebase enable is 0, active halt if 1.
// (RULE2) Active halt ends only on timebase interrupt or reset.
// (RULE3) Timebase wake from active halt skips stabilisation and services interrupt at once.
// (RULE4) Reset wake from active halt waits the stabilisation delay first.
// (RULE5) Halt entry forces interrupt mask to 10; pending interrupt wakes immediately.
// (RULE6) Active halt keeps only oscillator and timebase clocked.
// (RULE7) Active halt with timebase enable set suppresses watchdog reset.
// (RULE8) Software keeps timebase enable set for the wake delay after a wake.
// (RULE9) Clearing timebase enable early drops into full halt for the remaining delay.
// (RULE10) Full halt ends on reset or on the halt wake interrupt subset.
// (RULE11) Full halt exit restarts oscillator and waits 256 or 4096 cycles.
// (RULE12) Full halt stops oscillator, CPU and peripheral clocks.
// (RULE13) Watchdog halt option decides if full halt entry raises watchdog reset.
// (RULE14) Opcode byte 0x8E is decoded as the halt instruction.
// (RULE15) Interrupt service requests a condition code push before entering routine.
// (RULE16) Software should clear pending interrupts before halting.
// (RULE17) Software should set wake pin as pull-up interrupt input before halting.
// (RULE18) Explicit state machine; delay length strapped and sampled after reset.
module hmpc_top
  import hmpc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        op_valid,
  input  wire logic [7:0]  op_byte,
  input  wire logic        timebase_irq,
  input  wire logic        halt_wake_irq,
  input  wire logic        sys_reset_n_pin,
  input  wire logic        wdg_active,
  input  wire logic        cfg_long_delay_pin,
  input  wire logic        watchdog_halt_option_pin,
  output logic             cpu_stall,
  output logic             osc_enable,
  output logic             periph_clk_enable,
  output logic             timebase_clk_enable,
  output logic             imask_force,
  output logic      [1:0]  imask_value,
  output logic             irq_service,
  output logic             cc_push_req,
  output logic             reset_fetch,
  output logic             wdg_suppress,
  output logic             wdg_reset_req,
  output logic             irq
);

  hmpc_dly_if dly ();

  hmpc_delay u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .dly     (dly.tmr)
  );

  hmpc_state_e     state_reg;
  hmpc_state_e     state_next;
  logic            tb_en_reg;
  logic            win_reg;
  logic            wake_rst_reg;
  logic            svc_reg;
  logic            fetch_reg;
  logic            wdg_rst_reg;
  logic [EV_W-1:0] stat_reg;
  logic [EV_W-1:0] mask_reg;
  logic [31:0]     prdata_reg;
  logic            rst_s1_reg;
  logic            rst_s2_reg;
  logic            long_s1_reg;
  logic            long_s2_reg;
  logic            wopt_s1_reg;
  logic            wopt_s2_reg;
  logic [1:0]      cfg_cnt_reg;
  logic            long_sel_reg;
  logic            wdg_opt_reg;
  logic            halt_exec;
  logic            rst_wake;
  logic            dly_start;
  logic            wr_en;
  logic            addr_ok;
  logic [EV_W-1:0] ev_set;

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_s1_reg  <= 1'b1;
      rst_s2_reg  <= 1'b1;
      long_s1_reg <= 1'b0;
      long_s2_reg <= 1'b0;
      wopt_s1_reg <= 1'b0;
      wopt_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg  <= sys_reset_n_pin;
      rst_s2_reg  <= rst_s1_reg;
      long_s1_reg <= cfg_long_delay_pin;
      long_s2_reg <= long_s1_reg;
      wopt_s1_reg <= watchdog_halt_option_pin;
      wopt_s2_reg <= wopt_s1_reg;
    end
  end

  // Straps are static; captured once the synchronisers have settled after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_cnt_reg  <= '0;
      long_sel_reg <= 1'b0;
      wdg_opt_reg  <= 1'b0;
    end else if (cfg_cnt_reg != CFG_SETTLE_CYC) begin
      cfg_cnt_reg  <= cfg_cnt_reg + 2'h1;
      long_sel_reg <= long_s2_reg; // RULE18
      wdg_opt_reg  <= wopt_s2_reg; // RULE18
    end
  end

  assign rst_wake  = !rst_s2_reg;
  assign halt_exec = op_valid && (op_byte == HALT_OPCODE); // RULE14

  always_comb begin
    state_next = state_reg;
    dly_start  = 1'b0;
    case (state_reg)
      HMPC_RUN: begin
        if (halt_exec) begin
          state_next = tb_en_reg ? HMPC_ACTIVE_HALT : HMPC_FULL_HALT; // RULE1
        end else if (win_reg && !tb_en_reg && !dly.done) begin
          state_next = HMPC_GUARD_HALT; // RULE9
        end
      end
      HMPC_ACTIVE_HALT: begin
        if (rst_wake) begin
          state_next = HMPC_STABILISE; // RULE4
          dly_start  = 1'b1;
        end else if (timebase_irq) begin
          // No stabilisation, but the wake window starts for the guard check
          state_next = HMPC_RUN; // RULE2 RULE3
          dly_start  = 1'b1;
        end
      end
      HMPC_FULL_HALT: begin
        if (rst_wake || halt_wake_irq) begin
          state_next = HMPC_STABILISE; // RULE10 RULE11
          dly_start  = 1'b1;
        end
      end
      HMPC_GUARD_HALT: begin
        if (rst_wake) begin
          state_next = HMPC_STABILISE;
          dly_start  = 1'b1;
        end else if (dly.done || !dly.busy) begin
          state_next = HMPC_RUN; // RULE9
        end
      end
      HMPC_STABILISE: begin
        if (dly.done) begin
          state_next = HMPC_RUN; // RULE11
        end
      end
      default: state_next = HMPC_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HMPC_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign dly.start    = dly_start;
  assign dly.long_sel = long_sel_reg;

  // Wake window: open after a timebase wake from active halt, closed by the delay end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_reg <= 1'b0;
    end else if (state_reg == HMPC_ACTIVE_HALT && state_next == HMPC_RUN) begin
      win_reg <= 1'b1;
    end else if (dly.done || state_next == HMPC_STABILISE) begin
      win_reg <= 1'b0;
    end
  end

  // Remember why stabilisation began so the right exit is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_rst_reg <= 1'b0;
    end else if (state_next == HMPC_STABILISE && state_reg != HMPC_STABILISE) begin
      wake_rst_reg <= rst_wake;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_reg   <= 1'b0;
      fetch_reg <= 1'b0;
    end else begin
      svc_reg   <= (state_reg == HMPC_ACTIVE_HALT && !rst_wake && timebase_irq) ||
                   (state_reg == HMPC_STABILISE && dly.done && !wake_rst_reg); // RULE3 RULE15
      fetch_reg <= state_reg == HMPC_STABILISE && dly.done && wake_rst_reg; // RULE4 RULE11
    end
  end

  // Watchdog reset on full halt entry unless the option allows halting with it running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_rst_reg <= 1'b0;
    end else begin
      wdg_rst_reg <= state_reg == HMPC_RUN && halt_exec && !tb_en_reg && wdg_active && !wdg_opt_reg; // RULE13
    end
  end

  assign cpu_stall           = state_reg != HMPC_RUN;
  assign osc_enable          = !hmpc_osc_stopped(state_reg); // RULE11 RULE12
  assign timebase_clk_enable = !hmpc_osc_stopped(state_reg); // RULE6
  assign periph_clk_enable   = state_reg == HMPC_RUN; // RULE6 RULE12
  assign imask_force         = state_reg == HMPC_FULL_HALT || state_reg == HMPC_ACTIVE_HALT; // RULE5
  assign imask_value         = IMASK_HALT_LEVEL; // RULE5
  assign irq_service         = svc_reg;
  assign cc_push_req         = svc_reg; // RULE15
  assign reset_fetch         = fetch_reg;
  assign wdg_suppress        = state_reg == HMPC_ACTIVE_HALT && tb_en_reg; // RULE7
  assign wdg_reset_req       = wdg_rst_reg;

  // APB slave, zero wait states; read data is latched in the setup cycle
  assign wr_en   = psel && penable && pwrite;
  assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_STATE ||
                   paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_MASK;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= '0;
      case (paddr)
        ADDR_CTRL:     prdata_reg[CTRL_TB_EN_BIT] <= tb_en_reg;
        ADDR_STATE: begin
          prdata_reg[ST_STATE_LSB +: 3] <= state_reg;
          prdata_reg[ST_WIN_BIT]        <= win_reg;
          prdata_reg[ST_LONG_BIT]       <= long_sel_reg;
          prdata_reg[ST_WDGOPT_BIT]     <= wdg_opt_reg;
        end
        ADDR_IRQ_STAT: prdata_reg[EV_W-1:0] <= stat_reg;
        ADDR_IRQ_MASK: prdata_reg[EV_W-1:0] <= mask_reg;
        default:       prdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_en_reg <= CTRL_RESET;
      mask_reg  <= IRQ_MASK_RESET;
    end else if (wr_en) begin
      if (paddr == ADDR_CTRL) begin
        tb_en_reg <= pwdata[CTRL_TB_EN_BIT];
      end
      if (paddr == ADDR_IRQ_MASK) begin
        mask_reg <= pwdata[EV_W-1:0];
      end
    end
  end

  always_comb begin
    ev_set                  = '0;
    ev_set[EV_HALT_BIT]     = state_reg == HMPC_RUN && halt_exec;
    ev_set[EV_IRQ_WAKE_BIT] = svc_reg;
    ev_set[EV_RST_WAKE_BIT] = fetch_reg;
    ev_set[EV_EARLY_BIT]    = state_reg == HMPC_RUN && state_next == HMPC_GUARD_HALT;
  end

  // Write one to clear; a simultaneous event keeps its bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= IRQ_STAT_RESET;
    end else if (wr_en && paddr == ADDR_IRQ_STAT) begin
      stat_reg <= (stat_reg & ~pwdata[EV_W-1:0]) | ev_set;
    end else begin
      stat_reg <= stat_reg | ev_set;
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // Checks
  logic [DLY_W:0] stab_cyc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cyc <= '0;
    end else if (state_reg != HMPC_STABILISE) begin
      stab_cyc <= (DLY_W+1)'(1);
    end else begin
      stab_cyc <= stab_cyc + (DLY_W+1)'(1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt_cmd;
    state_reg == HMPC_RUN && halt_exec;
  endsequence

  sequence s_tb_wake;
    state_reg == HMPC_ACTIVE_HALT && timebase_irq && !rst_wake;
  endsequence

  property p_enter_full;
    s_halt_cmd ##0 (!tb_en_reg) |=> state_reg == HMPC_FULL_HALT && !osc_enable;
  endproperty
  a_enter_full: assert property (p_enter_full) else $error("halt with enable low not full halt"); // RULE1 RULE12

  property p_enter_active;
    s_halt_cmd ##0 tb_en_reg |=> state_reg == HMPC_ACTIVE_HALT && osc_enable && !periph_clk_enable;
  endproperty
  a_enter_active: assert property (p_enter_active) else $error("halt with enable high not active halt"); // RULE1 RULE6

  property p_active_hold;
    state_reg == HMPC_ACTIVE_HALT && !timebase_irq && !rst_wake |=> state_reg == HMPC_ACTIVE_HALT;
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active halt left without cause"); // RULE2

  property p_fast_wake;
    s_tb_wake |=> state_reg == HMPC_RUN && irq_service && cc_push_req ##1 !irq_service;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("timebase wake not immediate"); // RULE3 RULE15

  property p_rst_wake;
    state_reg == HMPC_ACTIVE_HALT && rst_wake |=> (state_reg == HMPC_STABILISE && !reset_fetch) [*8];
  endproperty
  a_rst_wake: assert property (p_rst_wake) else $error("reset wake skipped stabilisation"); // RULE4

  property p_imask;
    $rose(imask_force) |-> imask_value == 2'b10 && cpu_stall;
  endproperty
  a_imask: assert property (p_imask) else $error("mask not forced on halt entry"); // RULE5

  property p_wdg_quiet;
    state_reg == HMPC_ACTIVE_HALT && tb_en_reg |-> wdg_suppress ##1 !wdg_reset_req;
  endproperty
  a_wdg_quiet: assert property (p_wdg_quiet) else $error("watchdog not held off in active halt"); // RULE7

  property p_guard;
    state_reg == HMPC_RUN && win_reg && !tb_en_reg && !halt_exec && !dly.done |=>
      state_reg == HMPC_GUARD_HALT && !osc_enable;
  endproperty
  a_guard: assert property (p_guard) else $error("early enable clear not trapped"); // RULE9

  property p_full_wake;
    state_reg == HMPC_FULL_HALT && (halt_wake_irq || rst_wake) |=> state_reg == HMPC_STABILISE && osc_enable;
  endproperty
  a_full_wake: assert property (p_full_wake) else $error("full halt wake missed"); // RULE10 RULE11

  property p_stab_len;
    state_reg == HMPC_STABILISE && dly.done |-> stab_cyc == {1'b0, hmpc_dly_len(long_sel_reg)};
  endproperty
  a_stab_len: assert property (p_stab_len) else $error("stabilisation length wrong"); // RULE11

  property p_wdg_rst;
    s_halt_cmd ##0 (!tb_en_reg && wdg_active && !wdg_opt_reg) |=> wdg_reset_req;
  endproperty
  a_wdg_rst: assert property (p_wdg_rst) else $error("watchdog reset not raised"); // RULE13

  property p_decode;
    state_reg == HMPC_RUN && op_valid && op_byte != 8'h8E && !win_reg |=> state_reg == HMPC_RUN;
  endproperty
  a_decode: assert property (p_decode) else $error("non halt opcode halted"); // RULE14

endmodule // hmpc_top
`default_nettype wire

// ===== test/hmpc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module hmpc_cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raise_tb,
  input  wire logic raise_ext,
  input  wire logic clear_all,
  input  wire logic irq_service,
  output logic      timebase_irq,
  output logic      halt_wake_irq
);
  // Request latches drop when the vector is fetched, as the real latches do
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timebase_irq <= 1'b0;
    end else if (raise_tb) begin
      timebase_irq <= 1'b1;
    end else if (irq_service || clear_all) begin
      timebase_irq <= 1'b0;
    end
  end

  // The timebase request is serviced first when both are pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_wake_irq <= 1'b0;
    end else if (raise_ext) begin
      halt_wake_irq <= 1'b1;
    end else if ((irq_service && !timebase_irq) || clear_all) begin
      halt_wake_irq <= 1'b0;
    end
  end
endmodule // hmpc_cpu_model
`default_nettype wire

// ===== test/tb_halt_mode_power_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_halt_mode_power_controller;
  import hmpc_pkg::*;
  localparam int N = STAB_SHORT_TCPU;
  logic        pclk, presetn, psel, penable, pwrite, op_valid, rst_pin, wdg_active, long_pin, wopt_pin;
  logic        raise_tb, raise_ext, clear_all, timebase_irq, halt_wake_irq, last_err;
  logic [7:0]  paddr, op_byte, rnd_b;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, cpu_stall, osc_enable, periph_clk_enable, timebase_clk_enable, imask_force;
  logic [1:0]  imask_value;
  logic        irq_service, cc_push_req, reset_fetch, wdg_suppress, wdg_reset_req, irq;
  int          error_cnt = 0;
  int          checked = 0;
  int          n;

  hmpc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_byte(op_byte), .timebase_irq(timebase_irq), .halt_wake_irq(halt_wake_irq),
    .sys_reset_n_pin(rst_pin), .wdg_active(wdg_active), .cfg_long_delay_pin(long_pin),
    .watchdog_halt_option_pin(wopt_pin), .cpu_stall(cpu_stall), .osc_enable(osc_enable),
    .periph_clk_enable(periph_clk_enable), .timebase_clk_enable(timebase_clk_enable),
    .imask_force(imask_force), .imask_value(imask_value), .irq_service(irq_service),
    .cc_push_req(cc_push_req), .reset_fetch(reset_fetch), .wdg_suppress(wdg_suppress),
    .wdg_reset_req(wdg_reset_req), .irq(irq));

  hmpc_cpu_model partner (.pclk(pclk), .presetn(presetn), .raise_tb(raise_tb), .raise_ext(raise_ext),
    .clear_all(clear_all), .irq_service(irq_service), .timebase_irq(timebase_irq),
    .halt_wake_irq(halt_wake_irq));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic op(input logic [7:0] b);
    @(posedge pclk);
    op_valid <= 1'b1; op_byte <= b;
    @(posedge pclk);
    op_valid <= 1'b0;
  endtask

  task automatic raise(input logic t, input logic clr);
    @(posedge pclk);
    raise_tb <= t; raise_ext <= !t && !clr; clear_all <= clr;
    @(posedge pclk);
    raise_tb <= 1'b0; raise_ext <= 1'b0; clear_all <= 1'b0;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return irq_service;
      1: return reset_fetch;
      2: return wdg_reset_req;
      default: return !cpu_stall;
    endcase
  endfunction

  task automatic wait_evt(input int s, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    // Watchdog sized well beyond two full wake windows per test
    #(20 * 30000);
    error_cnt++;
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, op_valid, raise_tb, raise_ext, clear_all, wdg_active, long_pin} = '0;
    paddr = 8'h00; pwdata = 32'h0000_0000; op_byte = 8'h00;
    presetn = 1'b0; rst_pin = 1'b1; wopt_pin = 1'b1;
    q = $urandom(32'h71f7d120);
    do_reset();
    apb(0, ADDR_CTRL, 0);      chk("ctrl_rst", 32'h0000_0000, q);
    apb(0, ADDR_IRQ_STAT, 0);  chk("stat_rst", 32'h0000_0000, q);
    apb(0, ADDR_STATE, 0);     chk("state_rst", 32'h0000_0040, q);
    apb(0, 8'h10, 0);          chk("unmapped_err", 1, last_err);
    chk("unmapped_data", 32'h0000_0000, q);
    n = $urandom;
    apb(1, ADDR_IRQ_MASK, n);
    apb(0, ADDR_IRQ_MASK, 0);  chk("mask_rw", n & 32'h0000_000F, q);
    apb(1, ADDR_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      rnd_b = 8'($urandom);
      op((rnd_b == HALT_OPCODE) ? 8'h8F : rnd_b);
      @(negedge pclk);
      chk("run_other_op", 0, cpu_stall);
    end
    $display("test registers_and_opcodes done");

    raise(0, 1);
    apb(1, ADDR_CTRL, 0);
    op(HALT_OPCODE);
    @(negedge pclk);
    chk("full_osc", 0, osc_enable);
    chk("full_periph", 0, periph_clk_enable);
    chk("full_stall", 1, cpu_stall);
    chk("full_imask", 3'h6, {imask_force, imask_value});
    apb(0, ADDR_STATE, 0);     chk("full_state", 32'h0000_0041, q);
    @(negedge pclk);
    chk("irq_halt", 1, irq);
    apb(1, ADDR_IRQ_MASK, 32'h0000_0000);
    @(negedge pclk);
    chk("irq_masked", 0, irq);
    raise(0, 0);
    wait_evt(0, N + 20);
    chk("full_wake_cycles", N + 2, n);
    chk("cc_push", 1, cc_push_req);
    apb(1, ADDR_IRQ_STAT, 32'h0000_000F);
    apb(0, ADDR_IRQ_STAT, 0);  chk("stat_w1c", 32'h0000_0000, q);
    $display("test full_halt done");

    apb(1, ADDR_CTRL, 1);
    op(HALT_OPCODE);
    @(negedge pclk);
    chk("act_clocks", 3'h6, {osc_enable, timebase_clk_enable, periph_clk_enable});
    chk("act_imask", 3'h6, {imask_force, imask_value});
    apb(0, ADDR_STATE, 0);     chk("act_state", 32'h0000_0042, q);
    raise(0, 0);
    repeat (5) @(negedge pclk);
    chk("act_ext_ignored", 1, cpu_stall);
    raise(1, 0);
    wait_evt(0, 10);
    chk("act_wake_cycles", 2, n);
    apb(1, ADDR_CTRL, 0);
    repeat (2) @(negedge pclk);
    chk("guard_osc", 0, osc_enable);
    wait_evt(3, N + 10);
    // Window opened at the wake edge; the enable write lands three edges later, guard halt four
    chk("guard_ends", N - 4, n);
    apb(0, ADDR_IRQ_STAT, 0);  chk("early_flag", 1, q[EV_EARLY_BIT]);
    $display("test active_halt done");

    raise(0, 1);
    apb(1, ADDR_CTRL, 1);
    raise(1, 0);
    op(HALT_OPCODE);
    wait_evt(0, 6);
    chk("pending_wake", 1, n <= 2);
    repeat (N) @(posedge pclk);
    op(HALT_OPCODE);
    @(posedge pclk);
    rst_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    rst_pin <= 1'b1;
    wait_evt(1, N + 20);
    chk("rst_wake_win", 1, n >= N - 2 && n <= N + 4);
    $display("test pending_and_reset_wake done");

    // Second reset also switches to the long delay strap
    @(posedge pclk);
    wopt_pin <= 1'b0;
    long_pin <= 1'b1;
    do_reset();
    apb(0, ADDR_STATE, 0);     chk("state_long", 32'h0000_0020, q);
    apb(1, ADDR_CTRL, 1);
    @(posedge pclk);
    wdg_active <= 1'b1;
    op(HALT_OPCODE);
    wait_evt(2, 4);
    chk("act_no_wdg", 0, wdg_reset_req);
    chk("act_wdg_supp", 1, wdg_suppress);
    raise(1, 0);
    wait_evt(0, 10);
    chk("wdg_tb_wake", 1, irq_service);
    repeat (STAB_LONG_TCPU) @(posedge pclk);
    apb(1, ADDR_CTRL, 0);
    op(HALT_OPCODE);
    wait_evt(2, 4);
    chk("full_wdg_reset", 1, n);
    raise(0, 0);
    wait_evt(0, STAB_LONG_TCPU + 20);
    chk("long_wake_cycles", STAB_LONG_TCPU + 2, n);
    $display("test watchdog done");
    print_verdict();
  end
endmodule // tb_halt_mode_power_controller
`default_nettype wire
